// file: dgtp_defines.svh
/*
 * Offsets, field positions, reset values and widths for the dual
 * general timer block. Assumes a byte-addressed Wishbone slave window
 * of 256 bytes.
 */
`ifndef DGTP_DEFINES_SVH
`define DGTP_DEFINES_SVH

`define DGTP_ADR_W 8
`define DGTP_OFF_CTRL 8'h00
`define DGTP_OFF_T0_HIGH 8'h04
`define DGTP_OFF_T0_LOW 8'h08
`define DGTP_OFF_T0_IRQ 8'h0c
`define DGTP_OFF_T2_PER 8'h10
`define DGTP_OFF_T2_DA 8'h14
`define DGTP_OFF_T2_DB 8'h18
`define DGTP_OFF_T2_DC 8'h1c
`define DGTP_OFF_STAT 8'h20

`define DGTP_T0_W 16
`define DGTP_T2_W 14
`define DGTP_CTRL_W 8
`define DGTP_CTRL_RST 8'h00
`define DGTP_T0_EN 0
`define DGTP_T2_EN 1
`define DGTP_T0_SEL_LO 2
`define DGTP_T0_SEL_HI 4
`define DGTP_T2_DIV_LO 5
`define DGTP_T2_DIV_HI 6
`define DGTP_T2_SLOW 7
`define DGTP_SEL_SLOW 3'h4
`define DGTP_PRE_W 3
`define DGTP_T2_PER_RST 14'h0001

`define DGTP_ST_IRQ 0
`define DGTP_ST_W0 1
`define DGTP_ST_W2A 2
`define DGTP_ST_W2B 3
`define DGTP_ST_W2C 4

`endif

// file: dgtp_pkg.sv
/*
 * Types of the dual general timer block.
 * Assumes dgtp_defines.svh is on the include path.
 */
`default_nettype none
`include "dgtp_defines.svh"

package dgtp_pkg;
	typedef enum logic [1:0] {
		DGTP_T0_IDLE,
		DGTP_T0_HIGH,
		DGTP_T0_LOW
	} dgtp_t0_phase_e;

	typedef struct packed {
		logic [`DGTP_T0_W-1:0] high;
		logic [`DGTP_T0_W-1:0] low;
		logic [`DGTP_T0_W-1:0] irq;
	} dgtp_t0_cfg_s;

	typedef struct packed {
		logic [`DGTP_T2_W-1:0] period;
		logic [`DGTP_T2_W-1:0] duty_a;
		logic [`DGTP_T2_W-1:0] duty_b;
		logic [`DGTP_T2_W-1:0] duty_c;
	} dgtp_t2_cfg_s;
endpackage
`default_nettype wire

// file: dgtp_timers.sv
/*
 * Dual general timer with five pulse-width outputs, Wishbone slave.
 * Assumes a synchronous one-cycle slow_tick_i pulse at the slow rate.
 */
// Summary of operation
// - First timer counts 16 bits; high and low values span 0 to 65535.
// - First timer drives two outputs from one shared set of values.
// - First period is high plus one plus low plus one selected ticks.
// - First outputs are active for high value plus one ticks.
// - Periodic first-timer event every irq count plus one ticks.
// - Second timer counts with a 14-bit counter.
// - Second timer drives three separate outputs.
// - Second timer clock is system or slow clock divided by 1,2,4,8.
// - Second timer period is programmable from two ticks upward.
// - Each second output has own duty, from always off to always on.
`timescale 1ns/10ps
`default_nettype none
`include "dgtp_defines.svh"

module dgtp_timers
	import dgtp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_tick_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`DGTP_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic first_timer_wave_a,
	output logic first_timer_wave_b,
	output logic second_timer_wave_a,
	output logic second_timer_wave_b,
	output logic second_timer_wave_c,
	output logic t0_event_o
);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Divide by 2**sel: true once every 2**sel prescaler steps
	function automatic logic div_hit(input logic [1:0] sel,
		input logic [`DGTP_PRE_W-1:0] pre);
		logic [`DGTP_PRE_W-1:0] mask;
		mask = `DGTP_PRE_W'((1 << sel) - 1);
		return (pre & mask) == mask;
	endfunction

	logic [`DGTP_CTRL_W-1:0] ctrl_q;
	dgtp_t0_cfg_s t0_cfg_q, t0_sh_q;
	dgtp_t2_cfg_s t2_cfg_q, t2_sh_q;
	logic irq_flag_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic [`DGTP_PRE_W-1:0] pre_fast_q, pre_slow_q;
	logic tick0, tick2, t0_en, t2_en, wr, rd_req;
	dgtp_t0_phase_e t0_ph_q;
	logic [`DGTP_T0_W-1:0] t0_cnt_q, t0_icnt_q;
	logic w0_q, ev_q;
	logic [`DGTP_T2_W-1:0] t2_cnt_q, t2_cnt_d;
	dgtp_t2_cfg_s t2_sh_d;
	logic w2a_q, w2b_q, w2c_q;
	logic [2:0] t0_sel;

	default clocking dgtp_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	assign t0_en = ctrl_q[`DGTP_T0_EN];
	assign t2_en = ctrl_q[`DGTP_T2_EN];
	assign t0_sel = ctrl_q[`DGTP_T0_SEL_HI:`DGTP_T0_SEL_LO];
	assign rd_req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = rd_req && wb_we_i;

	// Bus answers one cycle after the request, then drops for a cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= rd_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0;
		end else if (rd_req) begin
			case (wb_adr_i)
			`DGTP_OFF_CTRL: rdat_q <= 32'(ctrl_q);
			`DGTP_OFF_T0_HIGH: rdat_q <= 32'(t0_cfg_q.high);
			`DGTP_OFF_T0_LOW: rdat_q <= 32'(t0_cfg_q.low);
			`DGTP_OFF_T0_IRQ: rdat_q <= 32'(t0_cfg_q.irq);
			`DGTP_OFF_T2_PER: rdat_q <= 32'(t2_cfg_q.period);
			`DGTP_OFF_T2_DA: rdat_q <= 32'(t2_cfg_q.duty_a);
			`DGTP_OFF_T2_DB: rdat_q <= 32'(t2_cfg_q.duty_b);
			`DGTP_OFF_T2_DC: rdat_q <= 32'(t2_cfg_q.duty_c);
			`DGTP_OFF_STAT: rdat_q <= 32'({w2c_q, w2b_q, w2a_q, w0_q,
				irq_flag_q});
			default: rdat_q <= 32'h0;
			endcase
		end
	end

	// Unmapped writes are acknowledged and dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `DGTP_CTRL_RST;
			t0_cfg_q <= '0;
			t2_cfg_q <= '0;
			t2_cfg_q.period <= `DGTP_T2_PER_RST;
		end else if (wr) begin
			case (wb_adr_i)
			`DGTP_OFF_CTRL: ctrl_q <= `DGTP_CTRL_W'(merge(32'(ctrl_q),
				wb_dat_i, wb_sel_i));
			`DGTP_OFF_T0_HIGH: t0_cfg_q.high <= `DGTP_T0_W'(merge(
				32'(t0_cfg_q.high), wb_dat_i, wb_sel_i));
			`DGTP_OFF_T0_LOW: t0_cfg_q.low <= `DGTP_T0_W'(merge(
				32'(t0_cfg_q.low), wb_dat_i, wb_sel_i));
			`DGTP_OFF_T0_IRQ: t0_cfg_q.irq <= `DGTP_T0_W'(merge(
				32'(t0_cfg_q.irq), wb_dat_i, wb_sel_i));
			`DGTP_OFF_T2_PER: t2_cfg_q.period <= `DGTP_T2_W'(merge(
				32'(t2_cfg_q.period), wb_dat_i, wb_sel_i));
			`DGTP_OFF_T2_DA: t2_cfg_q.duty_a <= `DGTP_T2_W'(merge(
				32'(t2_cfg_q.duty_a), wb_dat_i, wb_sel_i));
			`DGTP_OFF_T2_DB: t2_cfg_q.duty_b <= `DGTP_T2_W'(merge(
				32'(t2_cfg_q.duty_b), wb_dat_i, wb_sel_i));
			`DGTP_OFF_T2_DC: t2_cfg_q.duty_c <= `DGTP_T2_W'(merge(
				32'(t2_cfg_q.duty_c), wb_dat_i, wb_sel_i));
			default: ;
			endcase
		end
	end

	// Sticky event flag, write one to clear; a new event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_flag_q <= 1'b0;
		end else if (ev_q) begin
			irq_flag_q <= 1'b1;
		end else if (wr && wb_adr_i == `DGTP_OFF_STAT &&
			wb_sel_i[0] && wb_dat_i[`DGTP_ST_IRQ]) begin
			irq_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_fast_q <= '0;
			pre_slow_q <= '0;
		end else begin
			pre_fast_q <= pre_fast_q + 1'b1;
			if (slow_tick_i) begin
				pre_slow_q <= pre_slow_q + 1'b1;
			end
		end
	end

	assign tick0 = (t0_sel == `DGTP_SEL_SLOW) ? slow_tick_i :
		(!t0_sel[2] && div_hit(t0_sel[1:0], pre_fast_q));
	assign tick2 = ctrl_q[`DGTP_T2_SLOW] ?
		(slow_tick_i && div_hit(ctrl_q[`DGTP_T2_DIV_HI:`DGTP_T2_DIV_LO],
		pre_slow_q)) :
		div_hit(ctrl_q[`DGTP_T2_DIV_HI:`DGTP_T2_DIV_LO], pre_fast_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t0_ph_q <= DGTP_T0_IDLE;
			t0_cnt_q <= '0;
			t0_sh_q <= '0;
			w0_q <= 1'b0;
		end else if (!t0_en) begin
			t0_ph_q <= DGTP_T0_IDLE;
			t0_cnt_q <= '0;
			w0_q <= 1'b0;
		end else if (tick0) begin
			case (t0_ph_q)
			DGTP_T0_IDLE: begin
				t0_ph_q <= DGTP_T0_HIGH;
				t0_sh_q <= t0_cfg_q;
				w0_q <= 1'b1;
			end
			// high for high value plus one
			DGTP_T0_HIGH: begin
				if (t0_cnt_q == t0_sh_q.high) begin
					t0_ph_q <= DGTP_T0_LOW;
					t0_cnt_q <= '0;
					w0_q <= 1'b0;
				end else begin
					t0_cnt_q <= t0_cnt_q + 1'b1;
				end
			end
			DGTP_T0_LOW: begin
				if (t0_cnt_q == t0_sh_q.low) begin
					t0_ph_q <= DGTP_T0_HIGH;
					t0_cnt_q <= '0;
					t0_sh_q.high <= t0_cfg_q.high;
					t0_sh_q.low <= t0_cfg_q.low;
					w0_q <= 1'b1;
				end else begin
					t0_cnt_q <= t0_cnt_q + 1'b1;
				end
			end
			default: t0_ph_q <= DGTP_T0_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t0_icnt_q <= '0;
			ev_q <= 1'b0;
		end else begin
			ev_q <= 1'b0;
			if (!t0_en) begin
				t0_icnt_q <= '0;
			end else if (tick0 && t0_ph_q != DGTP_T0_IDLE) begin
				if (t0_icnt_q == t0_sh_q.irq) begin
					t0_icnt_q <= '0;
					ev_q <= 1'b1;
				end else begin
					t0_icnt_q <= t0_icnt_q + 1'b1;
				end
			end
		end
	end

	// Separate process keeps the event count from racing the reload above
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t0_event_o <= 1'b0;
		end else begin
			t0_event_o <= tick0 && t0_en && t0_ph_q != DGTP_T0_IDLE &&
				t0_icnt_q == t0_sh_q.irq;
		end
	end

	// wrap at period, period zero acts as one
	always_comb begin
		t2_cnt_d = t2_cnt_q;
		t2_sh_d = t2_sh_q;
		if (!t2_en) begin
			t2_cnt_d = '0;
			t2_sh_d = t2_cfg_q;
		end else if (tick2) begin
			if (t2_cnt_q >= t2_sh_q.period && t2_cnt_q != '0) begin
				t2_cnt_d = '0;
				t2_sh_d = t2_cfg_q;
			end else begin
				t2_cnt_d = t2_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t2_cnt_q <= '0;
			t2_sh_q <= '0;
		end else begin
			t2_cnt_q <= t2_cnt_d;
			t2_sh_q <= t2_sh_d;
		end
	end

	// compare per output, duty above period gives always on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w2a_q <= 1'b0;
			w2b_q <= 1'b0;
			w2c_q <= 1'b0;
		end else begin
			w2a_q <= t2_en && t2_cnt_d < t2_sh_d.duty_a;
			w2b_q <= t2_en && t2_cnt_d < t2_sh_d.duty_b;
			w2c_q <= t2_en && t2_cnt_d < t2_sh_d.duty_c;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	// both first outputs from one flop
	assign first_timer_wave_a = w0_q;
	assign first_timer_wave_b = w0_q;
	assign second_timer_wave_a = w2a_q;
	assign second_timer_wave_b = w2b_q;
	assign second_timer_wave_c = w2c_q;

	chk_t0_high_bound: assert property (
		t0_ph_q == DGTP_T0_HIGH |-> t0_cnt_q <= t0_sh_q.high)
		else $error("first timer count passed high value");
	chk_t0_shared_out: assert property (
		first_timer_wave_a == first_timer_wave_b)
		else $error("first timer outputs differ");
	chk_t0_low_phase: assert property (
		$rose(t0_ph_q == DGTP_T0_LOW) |-> !w0_q)
		else $error("first output active in low phase");
	chk_t0_high_out: assert property (
		t0_ph_q == DGTP_T0_HIGH |-> w0_q)
		else $error("first output inactive in high phase");
	chk_t0_event_pulse: assert property (
		t0_event_o |=> irq_flag_q)
		else $error("event did not set sticky flag");
	chk_t2_cnt_bound: assert property (
		t2_en && $stable(t2_sh_q.period) && t2_sh_q.period != '0 |->
		t2_cnt_q <= t2_sh_q.period)
		else $error("second count passed period");
	chk_t2_div_tick: assert property (
		tick2 && !ctrl_q[`DGTP_T2_SLOW] &&
		ctrl_q[`DGTP_T2_DIV_HI:`DGTP_T2_DIV_LO] == 2'h3 |->
		pre_fast_q == 3'h7)
		else $error("second timer divider wrong");
	chk_t2_zero_duty: assert property (
		t2_sh_d.duty_a == '0 |=> !w2a_q)
		else $error("zero duty output active");
	chk_t2_wrap: assert property (
		t2_en && tick2 && t2_cnt_q == t2_sh_q.period && t2_cnt_q != '0
		|=> t2_cnt_q == '0)
		else $error("second timer did not wrap");
	chk_t2_three_out: assert property (
		!t2_en |=> !w2a_q && !w2b_q && !w2c_q)
		else $error("second outputs active while off");
	chk_shadow_hold: assert property (
		t2_en && !(tick2 && t2_cnt_q == '0) && $past(t2_en) &&
		t2_cnt_q != '0 |-> $stable(t2_sh_q))
		else $error("second shadow changed mid period");
	chk_bus_ack: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	cov_t0_event: cover property (
		t0_event_o);
	cov_t0_period: cover property (
		t0_ph_q == DGTP_T0_LOW ##1 t0_ph_q == DGTP_T0_HIGH);
	cov_t2_full: cover property (
		t2_en && w2a_q && !w2b_q);

endmodule
`default_nettype wire

// file: dgtp_led_load.sv
/*
 * Behavioural load on the five wave outputs, measuring each wave's
 * high time and period in clk_i cycles.
 * Assumes the waves change only on clk_i rising edges.
 */
`timescale 1ns/10ps
`default_nettype none

module dgtp_led_load (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] wave_i,
	output logic [4:0][15:0] hi_o,
	output logic [4:0][15:0] per_o
);
	logic [4:0] prev_q;
	logic [4:0][15:0] run_q;

	// First period after reset is junk, so callers wait a few periods
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 5; i++) begin
			if (rst_i) begin
				run_q[i] <= 16'h0000;
			end else if (wave_i[i] && !prev_q[i]) begin
				per_o[i] <= run_q[i];
				run_q[i] <= 16'h0001;
			end else begin
				run_q[i] <= run_q[i] + 16'h0001;
			end
			if (!wave_i[i] && prev_q[i]) begin
				hi_o[i] <= run_q[i];
			end
		end
		prev_q <= rst_i ? 5'h00 : wave_i;
	end
endmodule

`default_nettype wire

// file: dual_general_timer_pwm_test.sv
/*
 * Self-checking bench for the dual general timer.
 * Assumes a slow tick every fourth clk_i cycle and the LED load model.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dgtp_defines.svh"

module dual_general_timer_pwm_test;
	import dgtp_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, t0_event_o;
	logic slow_tick_i = 1'b0;
	logic [1:0] tick_q = 2'h0;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	wire logic [4:0] wave;
	logic [4:0][15:0] hi, per;
	int mismatches = 0;
	int cmp_count = 0;

	dgtp_timers uut (.clk_i(clk_i), .rst_i(rst_i),
		.slow_tick_i(slow_tick_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .first_timer_wave_a(wave[0]),
		.first_timer_wave_b(wave[1]), .second_timer_wave_a(wave[2]),
		.second_timer_wave_b(wave[3]), .second_timer_wave_c(wave[4]),
		.t0_event_o(t0_event_o));
	dgtp_led_load load (.clk_i(clk_i), .rst_i(rst_i), .wave_i(wave),
		.hi_o(hi), .per_o(per));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Slow tick kept fast so slow modes finish in a short run
	always @(posedge clk_i) begin
		tick_q <= tick_q + 2'h1;
		slow_tick_i <= (tick_q == 2'h3);
	end

	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		check("ack", 32'h1, {31'h0, wb_ack_o});
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb(1'b1, adr, dat);
	endtask

	task automatic rdr(input logic [7:0] adr);
		wb(1'b0, adr, 32'h0);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	task automatic chk_wave(input int ch, input int p, input int h);
		check($sformatf("period of wave %0d", ch), p, per[ch]);
		check($sformatf("high time of wave %0d", ch), h, hi[ch]);
	endtask

	task automatic chk_level(input int ch, input logic lvl, input int k);
		repeat (k) begin
			@(posedge clk_i);
			check("steady level", {31'h0, lvl}, {31'h0, wave[ch]});
		end
	endtask

	task automatic t_regs();
		rdr(`DGTP_OFF_CTRL);
		check("ctrl reset", 32'h0, rd);
		rdr(`DGTP_OFF_T2_PER);
		check("t2 period reset", 32'h1, rd);
		wr(`DGTP_OFF_T0_HIGH, 32'hffffffff);
		rdr(`DGTP_OFF_T0_HIGH);
		check("t0 high width", 32'h0000ffff, rd);
		wr(`DGTP_OFF_T2_PER, 32'hffffffff);
		rdr(`DGTP_OFF_T2_PER);
		check("t2 period width", 32'h00003fff, rd);
		wr(8'h3c, 32'hffffffff);
		rdr(8'h3c);
		check("unmapped read", 32'h0, rd);
	endtask

	task automatic t_timer0();
		int s[5] = '{0, 1, 2, 3, 4};
		int m[5] = '{2, 0, 1, 3, 1};
		int n[5] = '{4, 0, 2, 0, 1};
		int d[5] = '{1, 2, 4, 8, 4};
		int p;
		for (int i = 0; i < 5; i++) begin
			p = (m[i] + n[i] + 2) * d[i];
			wr(`DGTP_OFF_CTRL, 32'h0);
			wr(`DGTP_OFF_T0_HIGH, m[i]);
			wr(`DGTP_OFF_T0_LOW, n[i]);
			wr(`DGTP_OFF_CTRL, (s[i] << 2) | 1);
			cyc(3 * p + 4);
			chk_wave(0, p, (m[i] + 1) * d[i]);
			chk_wave(1, p, (m[i] + 1) * d[i]);
		end
		// New high value while running lands at a period boundary
		wr(`DGTP_OFF_T0_HIGH, 32'h5);
		cyc(100);
		chk_wave(0, 32, 24);
		// Clock selects above the slow tick stop the first timer
		wr(`DGTP_OFF_CTRL, 32'h0);
		wr(`DGTP_OFF_CTRL, 32'h15);
		chk_level(0, 1'b0, 20);
	endtask

	task automatic wait_event(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (t0_event_o !== 1'b1 && k < 100);
	endtask

	task automatic t_event();
		int k;
		wr(`DGTP_OFF_CTRL, 32'h0);
		wr(`DGTP_OFF_T0_IRQ, 32'h4);
		wr(`DGTP_OFF_CTRL, 32'h1);
		wait_event(k);
		wait_event(k);
		check("event spacing", 5, k);
		rdr(`DGTP_OFF_STAT);
		check("sticky flag", 32'h1, {31'h0, rd[`DGTP_ST_IRQ]});
		wr(`DGTP_OFF_CTRL, 32'h0);
		wr(`DGTP_OFF_STAT, 32'h1);
		rdr(`DGTP_OFF_STAT);
		check("status cleared", 32'h0, rd);
	endtask

	task automatic t_timer2();
		int c[5] = '{32'h02, 32'h22, 32'h42, 32'h62, 32'h82};
		int d[5] = '{1, 2, 4, 8, 4};
		wr(`DGTP_OFF_T2_PER, 32'h9);
		wr(`DGTP_OFF_T2_DA, 32'h0);
		wr(`DGTP_OFF_T2_DB, 32'h3);
		wr(`DGTP_OFF_T2_DC, 32'hf);
		for (int i = 0; i < 5; i++) begin
			wr(`DGTP_OFF_CTRL, 32'h0);
			wr(`DGTP_OFF_CTRL, c[i]);
			cyc(30 * d[i] + 4);
			chk_wave(3, 10 * d[i], 3 * d[i]);
			chk_level(2, 1'b0, 10 * d[i]);
			chk_level(4, 1'b1, 10 * d[i]);
		end
		wr(`DGTP_OFF_CTRL, 32'h0);
		wr(`DGTP_OFF_T2_PER, 32'h1);
		wr(`DGTP_OFF_T2_DB, 32'h1);
		wr(`DGTP_OFF_CTRL, 32'h2);
		cyc(10);
		chk_wave(3, 2, 1);
	endtask

	initial begin
		#(20000 * 100);
		mismatches++;
		results();
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_timer0();
		t_event();
		t_timer2();
		results();
	end
endmodule

`default_nettype wire
